// ### rtl/can_mode_pkg.sv
// Constants and types shared by the CAN mode and low-power control block
package can_mode_pkg;

    // ==========================================================
    // Register map (byte addresses, one 32-bit word each)
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_CONFIG = 4'h4;
    localparam logic [3:0] ADDR_STATUS = 4'h8;

    // ==========================================================
    // Control word fields
    localparam int CTRL_SLEEP_REQ = 0;
    localparam int CTRL_INIT_REQ = 1;
    localparam int CTRL_WAKE_EN = 2;
    localparam int CTRL_WAKE_IRQ_EN = 3;
    localparam int CTRL_STOP_IN_WAIT = 4;
    localparam int CTRL_MODULE_EN = 7;

    // Configuration word fields, writable only in initialization mode
    localparam int CFG_LISTEN_ONLY = 0;
    localparam int CFG_LOOPBACK = 1;

    // Status word fields
    localparam int STAT_SLEEP_ACK = 0;
    localparam int STAT_INIT_ACK = 1;
    localparam int STAT_POWER_DOWN = 2;
    localparam int STAT_RESYNC = 3;
    localparam int STAT_WAKE_EVENT = 4;

    // ==========================================================
    // Values after reset: every control and status bit is zero
    localparam logic [31:0] CTRL_RESET = 32'h00000000;

    // ==========================================================
    // Cycle counts
    localparam int SLEEP_SYNC_CYCLES = 2;
    // Two extra cycles for the register side plus three for the protocol side
    localparam int INIT_SYNC_CYCLES = 5;
    localparam int RECOVERY_CYCLES = 16;
    localparam int RESYNC_BITS = 11;

    // ==========================================================
    // Enumerations
    typedef enum logic [1:0] {
        CPU_RUN,
        CPU_WAIT,
        CPU_STOP3,
        CPU_STOP12
    } cpu_mode_type;

    typedef enum logic [3:0] {
        ST_DISABLED,
        ST_NORMAL,
        ST_SLEEP_PEND,
        ST_SLEEP,
        ST_INIT_SYNC,
        ST_INIT,
        ST_POWER_DOWN,
        ST_RECOVER,
        ST_RESYNC
    } mode_state_type;

endpackage : can_mode_pkg

// ### rtl/mode_link_if.sv
// Link between the mode controller and its recessive-run detector
`timescale 1ns/1ps
interface mode_link_if;
    logic rx_bit;
    logic bit_tick;
    logic arm;
    logic activity;
    logic resync_done;

    modport ctrl (output rx_bit, output bit_tick, output arm, input activity, input resync_done);
    modport filt (input rx_bit, input bit_tick, input arm, output activity, output resync_done);
endinterface : mode_link_if

// ### rtl/wake_filter.sv
// Bus activity detector and consecutive recessive bit counter
`timescale 1ns/1ps
module wake_filter #(
    parameter int RESYNC_BITS = can_mode_pkg::RESYNC_BITS
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Controller side
    mode_link_if.filt link
);

    localparam int RW = $clog2(RESYNC_BITS + 1);
    localparam logic [RW-1:0] RUN_LAST = RW'(RESYNC_BITS - 1);

    typedef struct packed {
        logic [RW-1:0] run;
        logic done;
        logic act;
    } filt_state_type;

    filt_state_type q;
    filt_state_type d;

    always_comb begin
        d = q;
        // A dominant level counts as activity
        d.act = !link.rx_bit;
        if (!link.arm) begin
            d.run = '0;
            d.done = 1'b0;
        end else if (link.bit_tick && !q.done) begin
            if (link.rx_bit) begin
                if (q.run == RUN_LAST) begin
                    d.done = 1'b1;
                end else begin
                    d.run = q.run + RW'(1);
                end
            end else begin
                d.run = '0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign link.activity = q.act;
    assign link.resync_done = q.done;

endmodule : wake_filter

// ### rtl/can_mode_lowpower_ctrl.sv
// Operating-mode and low-power controller of the CAN block, with Avalon-MM registers
`timescale 1ns/1ps

// Summary of operation
// - Listen-only: receive, drive recessive, never start
// - Listen-only: own dominant bits looped to monitor
// - Loopback: tx feeds rx, pins isolated
// - Loopback: ignore ack slot, raise both interrupts
// - Module disabled stops clocks except register access
// - Sleep stops clocks except register access
// - Wake interrupt needs sleep, ack, both enables
// - Wait with stop bit: power-down, then normal, or sleep if it was asleep
// - Stop modes: power-down, light stop keeps sleep
// - Sleep waits until transmit buffers empty
// - Sleep after reception ends, else after sync
// - Acknowledge set once sleep is active
// - Bus-off count paused, no foreground move
// - Buffers reachable in sleep, no abort
// - Wake disabled masks rx, latched at entry
// - Wake by activity or cleared request only
// - After wake wait eleven recessive bits
// - Deferred actions released on wake
// - Init aborts traffic, transmit pin recessive
// - Init resets control, opens configuration writes
// - Init request synchronized before acknowledge
// - Power-down stops all, recovery if awake
module can_mode_lowpower_ctrl (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Avalon-MM slave
    input wire logic [3:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    // CPU power mode
    input wire can_mode_pkg::cpu_mode_type cpu_mode,
    // CAN pins
    input wire logic bus_rx_pin,
    output logic bus_tx_pin,
    // Protocol engine
    input wire logic core_tx,
    input wire logic bit_tick,
    input wire logic tx_pending,
    input wire logic receiving,
    input wire logic bus_idle,
    input wire logic bus_off,
    output logic core_rx,
    output logic core_clock_enable,
    output logic tx_start_allow,
    output logic core_abort,
    output logic bus_join,
    output logic ack_ignore,
    output logic own_frame_as_rx,
    output logic abort_allow,
    output logic rx_fg_move_allow,
    output logic recovery_count_enable,
    output logic config_write_allow,
    output logic deferred_release,
    output logic recovery_cycle,
    // Mode status
    output logic sleep_acknowledge,
    output logic init_acknowledge,
    output logic wakeup_irq
);

    typedef struct packed {
        logic rx_s1;
        logic rx_s2;
        logic rx_int;
        logic tx;
        can_mode_pkg::mode_state_type state;
        logic [4:0] cnt;
        logic sleep_request;
        logic init_request;
        logic wakeup_detect_enable;
        logic wakeup_irq_enable;
        logic stop_in_wait;
        logic module_enable;
        logic listen_only;
        logic loopback;
        logic sleep_ack;
        logic init_ack;
        logic wake_en_latched;
        logic was_asleep;
        logic wake_irq;
        logic wake_event;
        logic release_p;
        logic ack;
        logic [31:0] rdata;
    } ctrl_state_type;

    ctrl_state_type q;
    ctrl_state_type d;
    mode_link_if link ();

    logic online;
    logic pd_req;
    logic access_ok;
    logic wr_ctrl;
    logic wr_cfg;
    logic [31:0] ctrl_word;
    logic [31:0] cfg_word;
    logic [31:0] stat_word;

    // ==========================================================
    // Recessive-run detector
    wake_filter #(
        .RESYNC_BITS(can_mode_pkg::RESYNC_BITS)
    ) u_wake_filter (
        .clk(clk),
        .rst_n(rst_n),
        .link(link)
    );

    assign link.rx_bit = q.rx_int;
    assign link.bit_tick = bit_tick;
    assign link.arm = (q.state == can_mode_pkg::ST_RESYNC);

    // ==========================================================
    // Register views
    always_comb begin
        ctrl_word = can_mode_pkg::CTRL_RESET;
        ctrl_word[can_mode_pkg::CTRL_SLEEP_REQ] = q.sleep_request;
        ctrl_word[can_mode_pkg::CTRL_INIT_REQ] = q.init_request;
        ctrl_word[can_mode_pkg::CTRL_WAKE_EN] = q.wakeup_detect_enable;
        ctrl_word[can_mode_pkg::CTRL_WAKE_IRQ_EN] = q.wakeup_irq_enable;
        ctrl_word[can_mode_pkg::CTRL_STOP_IN_WAIT] = q.stop_in_wait;
        ctrl_word[can_mode_pkg::CTRL_MODULE_EN] = q.module_enable;
        cfg_word = '0;
        cfg_word[can_mode_pkg::CFG_LISTEN_ONLY] = q.listen_only;
        cfg_word[can_mode_pkg::CFG_LOOPBACK] = q.loopback;
        stat_word = '0;
        stat_word[can_mode_pkg::STAT_SLEEP_ACK] = q.sleep_ack;
        stat_word[can_mode_pkg::STAT_INIT_ACK] = q.init_ack;
        stat_word[can_mode_pkg::STAT_POWER_DOWN] = (q.state == can_mode_pkg::ST_POWER_DOWN);
        stat_word[can_mode_pkg::STAT_RESYNC] = (q.state == can_mode_pkg::ST_RESYNC);
        stat_word[can_mode_pkg::STAT_WAKE_EVENT] = q.wake_event;
    end

    // ==========================================================
    // Mode decode
    assign online = (q.state == can_mode_pkg::ST_NORMAL) || (q.state == can_mode_pkg::ST_SLEEP_PEND);
    // Light stop keeps an established sleep; every other stop or a gated wait powers down
    assign pd_req = q.module_enable && ((cpu_mode == can_mode_pkg::CPU_STOP12)
        || (cpu_mode == can_mode_pkg::CPU_WAIT && q.stop_in_wait)
        || (cpu_mode == can_mode_pkg::CPU_STOP3 && q.state != can_mode_pkg::ST_SLEEP));
    // Power-down blocks the registers: reads give zero, writes are dropped
    assign access_ok = (q.state != can_mode_pkg::ST_POWER_DOWN);
    assign wr_ctrl = write && q.ack && access_ok && (address == can_mode_pkg::ADDR_CTRL);
    assign wr_cfg = write && q.ack && access_ok && (address == can_mode_pkg::ADDR_CONFIG);

    // ==========================================================
    // Next state
    always_comb begin
        d = q;
        d.rx_s1 = bus_rx_pin;
        d.rx_s2 = q.rx_s1;
        d.release_p = 1'b0;
        d.wake_irq = 1'b0;

        // Bus slave: one wait cycle, data registered for the answering edge
        d.ack = (read || write) && !q.ack;
        if (read && !q.ack) begin
            d.rdata = '0;
            if (access_ok) begin
                unique case (address)
                    can_mode_pkg::ADDR_CTRL: d.rdata = ctrl_word;
                    can_mode_pkg::ADDR_CONFIG: d.rdata = cfg_word;
                    can_mode_pkg::ADDR_STATUS: d.rdata = stat_word;
                    default: d.rdata = '0;
                endcase
            end
        end

        if (wr_ctrl) begin
            // Requests cannot be withdrawn before their acknowledge
            d.sleep_request = writedata[can_mode_pkg::CTRL_SLEEP_REQ]
                || (q.sleep_request && !q.sleep_ack);
            d.init_request = writedata[can_mode_pkg::CTRL_INIT_REQ]
                || (q.init_request && !q.init_ack);
            d.wakeup_detect_enable = writedata[can_mode_pkg::CTRL_WAKE_EN];
            d.wakeup_irq_enable = writedata[can_mode_pkg::CTRL_WAKE_IRQ_EN];
            d.stop_in_wait = writedata[can_mode_pkg::CTRL_STOP_IN_WAIT];
            d.module_enable = writedata[can_mode_pkg::CTRL_MODULE_EN];
            // Reading is not enough to clear: a write of zero or entry into init drops it
            d.wake_event = q.wake_event && writedata[can_mode_pkg::STAT_WAKE_EVENT];
        end
        if (wr_cfg && q.init_ack) begin
            d.listen_only = writedata[can_mode_pkg::CFG_LISTEN_ONLY];
            d.loopback = writedata[can_mode_pkg::CFG_LOOPBACK];
        end

        if (!q.module_enable) begin
            d.state = can_mode_pkg::ST_DISABLED;
            d.sleep_ack = 1'b0;
            d.init_ack = 1'b0;
        end else if (pd_req && q.state != can_mode_pkg::ST_POWER_DOWN) begin
            d.state = can_mode_pkg::ST_POWER_DOWN;
            d.was_asleep = (q.state == can_mode_pkg::ST_SLEEP);
        end else begin
            unique case (q.state)
                can_mode_pkg::ST_DISABLED: begin
                    d.state = can_mode_pkg::ST_NORMAL;
                end
                can_mode_pkg::ST_NORMAL: begin
                    d.cnt = '0;
                    if (q.init_request) begin
                        d.state = can_mode_pkg::ST_INIT_SYNC;
                    end else if (q.sleep_request) begin
                        d.state = can_mode_pkg::ST_SLEEP_PEND;
                    end
                end
                can_mode_pkg::ST_SLEEP_PEND: begin
                    if (q.init_request) begin
                        d.state = can_mode_pkg::ST_INIT_SYNC;
                        d.cnt = '0;
                    end else if (!tx_pending && !receiving && bus_idle) begin
                        d.cnt = q.cnt + 5'h01;
                        if (q.cnt == 5'(can_mode_pkg::SLEEP_SYNC_CYCLES - 1)) begin
                            d.state = can_mode_pkg::ST_SLEEP;
                            d.sleep_ack = 1'b1;
                            // Enable is sampled once, at entry
                            d.wake_en_latched = q.wakeup_detect_enable;
                        end
                    end else begin
                        d.cnt = '0;
                    end
                end
                can_mode_pkg::ST_SLEEP: begin
                    if (q.init_request) begin
                        d.state = can_mode_pkg::ST_INIT_SYNC;
                        d.cnt = '0;
                        d.sleep_ack = 1'b0;
                    end else if (!q.sleep_request) begin
                        d.state = can_mode_pkg::ST_RESYNC;
                        d.sleep_ack = 1'b0;
                        d.release_p = 1'b1;
                    end else if (q.wake_en_latched && link.activity) begin
                        d.state = can_mode_pkg::ST_RESYNC;
                        d.sleep_ack = 1'b0;
                        d.sleep_request = 1'b0;
                        d.release_p = 1'b1;
                        d.wake_irq = q.wakeup_irq_enable;
                        d.wake_event = 1'b1;
                    end
                end
                can_mode_pkg::ST_INIT_SYNC: begin
                    d.cnt = q.cnt + 5'h01;
                    if (q.cnt == 5'(can_mode_pkg::INIT_SYNC_CYCLES - 1)) begin
                        d.state = can_mode_pkg::ST_INIT;
                        d.init_ack = 1'b1;
                        // Control bits other than the request and enable go back to reset
                        d.sleep_request = 1'b0;
                        d.sleep_ack = 1'b0;
                        d.wakeup_detect_enable = 1'b0;
                        d.wakeup_irq_enable = 1'b0;
                        d.stop_in_wait = 1'b0;
                        d.wake_event = 1'b0;
                    end
                end
                can_mode_pkg::ST_INIT: begin
                    if (!q.init_request) begin
                        d.state = can_mode_pkg::ST_RESYNC;
                        d.init_ack = 1'b0;
                    end
                end
                can_mode_pkg::ST_POWER_DOWN: begin
                    d.cnt = '0;
                    if (!pd_req) begin
                        d.state = q.was_asleep ? can_mode_pkg::ST_SLEEP
                            : can_mode_pkg::ST_RECOVER;
                    end
                end
                can_mode_pkg::ST_RECOVER: begin
                    d.cnt = q.cnt + 5'h01;
                    if (q.cnt == 5'(can_mode_pkg::RECOVERY_CYCLES - 1)) begin
                        d.state = can_mode_pkg::ST_NORMAL;
                    end
                end
                can_mode_pkg::ST_RESYNC: begin
                    if (link.resync_done) begin
                        d.state = can_mode_pkg::ST_NORMAL;
                    end
                end
            endcase
        end

        // Pin and monitor path
        if (online && !q.listen_only && !q.loopback) begin
            d.tx = core_tx;
        end else begin
            d.tx = 1'b1;
        end
        if (q.loopback) begin
            d.rx_int = core_tx;
        end else if (q.listen_only) begin
            d.rx_int = core_tx && q.rx_s2;
        end else if (q.state == can_mode_pkg::ST_SLEEP && !q.wake_en_latched) begin
            d.rx_int = 1'b1;
        end else begin
            d.rx_int = q.rx_s2;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // ==========================================================
    // Outputs
    assign readdata = q.rdata;
    assign waitrequest = (read || write) && !q.ack;
    assign bus_tx_pin = q.tx;
    assign core_rx = q.rx_int;
    // Register access keeps running in sleep; only the protocol side is gated
    assign core_clock_enable = !(q.state == can_mode_pkg::ST_DISABLED
        || q.state == can_mode_pkg::ST_SLEEP
        || q.state == can_mode_pkg::ST_POWER_DOWN);
    assign tx_start_allow = online && !q.listen_only;
    assign core_abort = (q.state == can_mode_pkg::ST_INIT_SYNC) || (q.state == can_mode_pkg::ST_INIT)
        || (q.state == can_mode_pkg::ST_POWER_DOWN)
        || (q.state == can_mode_pkg::ST_DISABLED);
    assign bus_join = online;
    assign ack_ignore = q.loopback;
    assign own_frame_as_rx = q.loopback;
    assign abort_allow = (q.state != can_mode_pkg::ST_SLEEP);
    assign rx_fg_move_allow = (q.state != can_mode_pkg::ST_SLEEP);
    assign recovery_count_enable = bus_off && core_clock_enable;
    assign config_write_allow = q.init_ack;
    assign deferred_release = q.release_p;
    assign recovery_cycle = (q.state == can_mode_pkg::ST_RECOVER);
    assign sleep_acknowledge = q.sleep_ack;
    assign init_acknowledge = q.init_ack;
    assign wakeup_irq = q.wake_irq;

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    property p_listen_recessive;
        q.listen_only |=> bus_tx_pin && !tx_start_allow;
    endproperty
    a_listen_recessive: assert property (p_listen_recessive) else $error("listen-only drove bus");

    property p_loop_feed;
        q.loopback && $past(q.loopback) |-> core_rx == $past(core_tx);
    endproperty
    a_loop_feed: assert property (p_loop_feed) else $error("loopback rx not own tx");

    property p_wake_irq_cause;
        wakeup_irq |-> $past(q.sleep_ack && q.sleep_request && q.wake_en_latched
            && q.wakeup_irq_enable && link.activity);
    endproperty
    a_wake_irq_cause: assert property (p_wake_irq_cause) else $error("wake irq without cause");

    property p_sleep_waits_tx;
        q.state == can_mode_pkg::ST_SLEEP_PEND && tx_pending && !pd_req
            && q.module_enable |=> !sleep_acknowledge;
    endproperty
    a_sleep_waits_tx: assert property (p_sleep_waits_tx) else $error("slept with tx pending");

    property p_init_delay;
        q.state == can_mode_pkg::ST_NORMAL && q.init_request && !pd_req && q.module_enable
            |=> !init_acknowledge [*5];
    endproperty
    a_init_delay: assert property (p_init_delay) else $error("init ack too early");

    property p_init_tx_recessive;
        init_acknowledge ##1 init_acknowledge |-> bus_tx_pin;
    endproperty
    a_init_tx_recessive: assert property (p_init_tx_recessive) else $error("tx dominant in init");

    property p_pd_tx_recessive;
        q.state == can_mode_pkg::ST_POWER_DOWN |=> bus_tx_pin
            && (readdata == '0 || !$past(read && !q.ack));
    endproperty
    a_pd_tx_recessive: assert property (p_pd_tx_recessive) else $error("power-down leak");

    property p_sleep_no_abort;
        q.state == can_mode_pkg::ST_SLEEP |-> !abort_allow && !rx_fg_move_allow && !core_clock_enable;
    endproperty
    a_sleep_no_abort: assert property (p_sleep_no_abort) else $error("activity while asleep");

    property p_resync_hold;
        $rose(q.state == can_mode_pkg::ST_RESYNC) |-> !bus_join [*2];
    endproperty
    a_resync_hold: assert property (p_resync_hold) else $error("joined before resync");

endmodule : can_mode_lowpower_ctrl

// ### sim/can_node_model.sv
// Far-side CAN node: wired-AND bus with a commandable dominant driver
`timescale 1ns/1ps
module can_node_model (
    // Bus
    input wire logic bus_tx_pin,
    output logic bus_rx_pin,
    // Scenario control
    input wire logic drive_dominant
);
    // ==========================================================
    // Open bus: any dominant driver wins, idle level is recessive
    assign bus_rx_pin = bus_tx_pin & ~drive_dominant;
endmodule : can_node_model

// ### sim/can_mode_lowpower_ctrl_tb.sv
// Self-checking testbench of the CAN mode and low-power controller
`timescale 1ns/1ps
module can_mode_lowpower_ctrl_tb;
    logic clk = 1'b0, rst_n = 1'b0, read = 1'b0, write = 1'b0;
    logic [3:0] address = 4'h0;
    logic [31:0] writedata = 32'h0, rd;
    logic core_tx = 1'b1, bit_tick = 1'b0, tx_pending = 1'b0, dom = 1'b0;
    can_mode_pkg::cpu_mode_type cpu_mode = can_mode_pkg::CPU_RUN;
    wire logic [31:0] readdata;
    wire logic waitrequest, rx, tx, cce, wirq, sack, iack, join_o, abt, aa, fg, cwa, aign, own;
    int num_errors = 0, comparisons = 0, cyc = 0, n;
    can_mode_lowpower_ctrl DUT (.clk(clk), .rst_n(rst_n), .address(address), .read(read),
        .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
        .cpu_mode(cpu_mode), .bus_rx_pin(rx), .bus_tx_pin(tx), .core_tx(core_tx),
        .bit_tick(bit_tick), .tx_pending(tx_pending), .receiving(1'b0), .bus_idle(1'b1),
        .bus_off(1'b0), .core_rx(), .core_clock_enable(cce), .tx_start_allow(),
        .core_abort(abt), .bus_join(join_o), .ack_ignore(aign), .own_frame_as_rx(own),
        .abort_allow(aa), .rx_fg_move_allow(fg), .recovery_count_enable(),
        .config_write_allow(cwa), .deferred_release(), .recovery_cycle(),
        .sleep_acknowledge(sack), .init_acknowledge(iack), .wakeup_irq(wirq));
    can_node_model node (.bus_tx_pin(tx), .bus_rx_pin(rx), .drive_dominant(dom));
    always #12.5 clk = ~clk;
    // ==========================================================
    // Shared tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask : chk
    // Request held until the rising edge that samples waitrequest low; data taken there
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        address <= a;
        writedata <= d;
        write <= wr;
        read <= ~wr;
        do @(posedge clk); while (waitrequest !== 1'b0);
        rd = readdata;
        write <= 1'b0;
        read <= 1'b0;
    endtask : bus
    task automatic ticks(input int k);
        repeat (k) begin
            @(posedge clk) bit_tick <= 1'b1;
            @(posedge clk) bit_tick <= 1'b0;
        end
        repeat (3) @(negedge clk);
    endtask : ticks
    task automatic tally_and_finish();
        $display("comparisons=%0d num_errors=%0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : tally_and_finish
    // ==========================================================
    // Scenarios
    task automatic sc_sleep();
        tx_pending <= 1'b1;
        bus(1'b1, can_mode_pkg::ADDR_CTRL, 32'h8d);
        repeat (10) @(negedge clk);
        chk(sack, 1'b0);
        @(posedge clk);
        tx_pending <= 1'b0;
        for (n = 0; n < 20 && sack !== 1'b1; n++) @(negedge clk);
        chk({sack, cce, aa, fg, tx}, 5'b10001);
        bus(1'b0, can_mode_pkg::ADDR_STATUS, 32'h0);
        chk(rd[can_mode_pkg::STAT_SLEEP_ACK], 1'b1);
    endtask : sc_sleep
    task automatic sc_wake();
        dom <= 1'b1;
        for (n = 0; n < 20 && wirq !== 1'b1; n++) @(negedge clk);
        chk(wirq, 1'b1);
        @(posedge clk);
        dom <= 1'b0;
        repeat (6) @(negedge clk);
        chk({sack, join_o}, 2'b00);
        ticks(10);
        chk(join_o, 1'b0);
        ticks(1);
        chk(join_o, 1'b1);
    endtask : sc_wake
    task automatic sc_init();
        bus(1'b1, can_mode_pkg::ADDR_CTRL, 32'h82);
        for (n = 0; n < 40 && iack !== 1'b1; n++) @(negedge clk);
        chk(n >= 5, 1'b1);
        chk({tx, abt, cwa}, 3'b111);
        bus(1'b0, can_mode_pkg::ADDR_CTRL, 32'h0);
        chk(rd[can_mode_pkg::CTRL_WAKE_EN], 1'b0);
        bus(1'b1, can_mode_pkg::ADDR_CONFIG, 32'h2);
        bus(1'b1, can_mode_pkg::ADDR_CTRL, 32'h80);
        ticks(11);
        @(posedge clk);
        core_tx <= 1'b0;
        repeat (3) @(negedge clk);
        chk({tx, aign, own, join_o}, 4'b1111);
    endtask : sc_init
    task automatic sc_power();
        cpu_mode <= can_mode_pkg::CPU_STOP12;
        repeat (3) @(negedge clk);
        bus(1'b0, can_mode_pkg::ADDR_CTRL, 32'h0);
        chk(rd, 32'h0);
        chk({tx, cce}, 2'b10);
    endtask : sc_power
    // ==========================================================
    // Main sequence and hang guard
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            num_errors++;
            tally_and_finish();
        end
    end
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        // The pin leaves its reset value of zero one edge after release
        repeat (2) @(negedge clk);
        chk({cce, tx}, 2'b01);
        bus(1'b1, can_mode_pkg::ADDR_CTRL, 32'h80);
        repeat (2) @(negedge clk);
        chk(cce, 1'b1);
        sc_sleep();
        sc_wake();
        sc_init();
        sc_power();
        tally_and_finish();
    end
endmodule : can_mode_lowpower_ctrl_tb
